/* inc/cif_defs.vh */
/*
  Constants for the CAN identifier filter and multiframe display block:
  register byte offsets, control field positions, reset values, token kinds.
  Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
*/
`ifndef CIF_DEFS_VH
`define CIF_DEFS_VH

// Register byte offsets
`define CIF_OFF_CTRL        8'h00
`define CIF_OFF_FILTER      8'h04
`define CIF_OFF_FILTER_SHRT 8'h08
`define CIF_OFF_MASK        8'h0c
`define CIF_OFF_MASK_SHRT   8'h10
`define CIF_OFF_MON_BYTE    8'h14
`define CIF_OFF_STATUS      8'h18
`define CIF_OFF_RX_TOKEN    8'h1c

// Control register fields
`define CIF_CTRL_FMT_BIT    0
`define CIF_CTRL_HDR_BIT    1
`define CIF_CTRL_ID29_BIT   2
`define CIF_CTRL_MON_LSB    4
`define CIF_CTRL_DEFS_BIT   8

// Monitor modes
`define CIF_MON_OFF         2'h0
`define CIF_MON_ALL         2'h1
`define CIF_MON_RX          2'h2
`define CIF_MON_TX          2'h3

// Reset and default values
`define CIF_FILTER_RST      29'h0000000
`define CIF_MASK_RST        29'h0000000
`define CIF_FMT_RST         1'h1
`define CIF_HDR_RST         1'h0
`define CIF_ID29_RST        1'h0
`define CIF_MON_BYTE_RST    8'h00

// Identifier widths
`define CIF_STD_ID_MASK     29'h00007ff

// Protocol control nibbles
`define CIF_PCI_SINGLE      4'h0
`define CIF_PCI_FIRST       4'h1
`define CIF_PCI_CONSEC      4'h2

// Output token kinds, bits [30:28] of a token
`define CIF_TOK_ID          3'h1
`define CIF_TOK_LEN         3'h2
`define CIF_TOK_SEQ         3'h3
`define CIF_TOK_BYTE        3'h4
`define CIF_TOK_EOL         3'h5

// Token FIFO shape
`define CIF_TOK_WIDTH       31
`define CIF_FIFO_DEPTH      4

// AXI responses
`define CIF_RESP_OKAY       2'h0
`define CIF_RESP_SLVERR     2'h2

`endif

/* src/cif_filter_display.v */
/*
  CAN receive identifier filter and multiframe display formatter, plus
  its token FIFO and AXI4-Lite register slave.
  Assumes the CAN controller hands over whole received frames on the
  rx_frame port, synchronous to mclk, and that software drains the
  display tokens by reading the token register.
*/
// Functional notes
// R1: Programmable 29-bit filter, four-byte load
// R2: Mask bit one compares, zero ignores
// R3: 11-bit mode compares low 11 bits
// R4: Short three-digit forms zero-extend to store
// R5: Monitor shows frames passing filter and byte
// R6: Monitor modes keep node silent on bus
// R7: Filter applies to every received frame
// R8: Set-defaults restores filter, mask and settings
// R9: Auto formatting enabled after reset
// R10: Formatted segments open with sequence digit
// R11: Byte count line precedes first frame segment
// R12: Sequence digit wraps from F to 0
// R13: Decode control byte, first or consecutive
// R14: Headers on prints identifier and raw bytes; identifier bit 28 is not shown
// R15: Formatting strips single frame control byte
// R16: Accept when masked xor is zero
`timescale 1ns/1ps
`include "cif_defs.vh"

module cif_fifo #(
  parameter WIDTH = 31,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Occupancy
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_push;
  wire do_pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // cif_fifo

module cif_filter_display (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Received frames from the CAN controller
  input wire rx_frame_valid,
  output reg rx_frame_ready,
  input wire [28:0] rx_frame_id,
  input wire [3:0] rx_frame_len,
  input wire [63:0] rx_frame_data,
  // To the CAN controller: no ack and no error frames while high
  output reg bus_silent
);
  localparam S_IDLE = 3'h0;
  localparam S_ID = 3'h1;
  localparam S_LEN = 3'h2;
  localparam S_LEN_EOL = 3'h3;
  localparam S_SEQ = 3'h4;
  localparam S_BYTE = 3'h5;
  localparam S_EOL = 3'h6;

  // Masked compare over the active identifier width
  function id_pass;
    input [28:0] id;
    input [28:0] filt;
    input [28:0] msk;
    input id29;
    reg [28:0] width_mask;
    begin
      width_mask = id29 ? 29'h1fffffff : `CIF_STD_ID_MASK; // R3
      id_pass = (((id ^ filt) & msk & width_mask) == 29'h0000000); // R16 R2
    end
  endfunction

  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apply_strb[i*8 +: 8] = strb[i] ? wdat[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  function [7:0] byte_at;
    input [63:0] data;
    input [3:0] idx;
    begin
      byte_at = data[idx[2:0]*8 +: 8];
    end
  endfunction

  reg [28:0] filter_reg;
  reg [28:0] mask_reg;
  reg fmt_reg;
  reg hdr_reg;
  reg id29_reg;
  reg [1:0] mon_reg;
  reg [7:0] mon_byte_reg;
  reg [7:0] acc_cnt_reg;
  reg [7:0] drop_cnt_reg;

  reg [7:0] awaddr_reg;
  reg aw_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_have_reg;

  reg [2:0] state_reg;
  reg [28:0] id_reg;
  reg [63:0] data_reg;
  reg [3:0] idx_reg;
  reg [3:0] end_reg;
  reg [3:0] seq_reg;

  wire [31:0] ctrl_word;
  wire [31:0] status_word;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [30:0] fifo_out_data;
  wire [2:0] fifo_level;
  reg tok_valid;
  reg [30:0] tok_data;
  reg fifo_pop;
  reg mon_pass;
  reg frame_ok;
  wire wr_go;
  wire [31:0] wr_merged_filt;
  wire [31:0] wr_merged_mask;
  wire [31:0] wr_merged_ctrl;
  wire [31:0] wr_merged_mon;

  assign ctrl_word = {26'h0000000, mon_reg, 1'b0, id29_reg, hdr_reg, fmt_reg};
  assign status_word = {8'h00, drop_cnt_reg, acc_cnt_reg, 3'h0, fifo_level,
                        bus_silent, (state_reg != S_IDLE)};
  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_merged_filt = apply_strb({3'h0, filter_reg}, wdata_reg, wstrb_reg);
  assign wr_merged_mask = apply_strb({3'h0, mask_reg}, wdata_reg, wstrb_reg);
  assign wr_merged_ctrl = apply_strb(ctrl_word, wdata_reg, wstrb_reg);
  assign wr_merged_mon = apply_strb({24'h000000, mon_byte_reg}, wdata_reg, wstrb_reg);

  // Monitor byte match; an 11-bit id holds only 3 receiver bits
  always @* begin
    case (mon_reg)
      `CIF_MON_RX: begin
        if (id29_reg) begin
          mon_pass = (rx_frame_id[15:8] == mon_byte_reg);
        end else begin
          mon_pass = (rx_frame_id[10:8] == mon_byte_reg[2:0]);
        end
      end
      `CIF_MON_TX: mon_pass = (rx_frame_id[7:0] == mon_byte_reg);
      default: mon_pass = 1'b1;
    endcase
    frame_ok = id_pass(rx_frame_id, filter_reg, mask_reg, id29_reg) && mon_pass; // R5 R7
  end

  cif_fifo #(
    .WIDTH(`CIF_TOK_WIDTH),
    .DEPTH(`CIF_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(tok_valid),
    .in_ready(fifo_in_ready),
    .in_data(tok_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Token for the current display state
  always @* begin
    tok_valid = 1'b0;
    tok_data = {`CIF_TOK_EOL, 28'h0000000};
    case (state_reg)
      S_ID: begin
        tok_valid = 1'b1;
        // Payload is 28 bits wide, so identifier bit 28 is not shown
        tok_data = {`CIF_TOK_ID, id29_reg ? id_reg[27:0] : id_reg[27:0] & 28'h00007ff}; // R14
      end
      S_LEN: begin
        tok_valid = 1'b1;
        tok_data = {`CIF_TOK_LEN, 16'h0000, data_reg[3:0], data_reg[15:8]}; // R11
      end
      S_LEN_EOL: tok_valid = 1'b1;
      S_SEQ: begin
        tok_valid = 1'b1;
        tok_data = {`CIF_TOK_SEQ, 24'h000000, seq_reg}; // R10
      end
      S_BYTE: begin
        tok_valid = (idx_reg < end_reg);
        tok_data = {`CIF_TOK_BYTE, 20'h00000, byte_at(data_reg, idx_reg)};
      end
      S_EOL: tok_valid = 1'b1;
      default: tok_valid = 1'b0;
    endcase
  end

  // Frame intake and display sequencing
  always @(posedge mclk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      rx_frame_ready <= 1'b0;
      id_reg <= 29'h0000000;
      data_reg <= 64'h0000000000000000;
      idx_reg <= 4'h0;
      end_reg <= 4'h0;
      seq_reg <= 4'h0;
      acc_cnt_reg <= 8'h00;
      drop_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        S_IDLE: begin
          rx_frame_ready <= 1'b1;
          if (rx_frame_valid && rx_frame_ready) begin
            id_reg <= rx_frame_id;
            data_reg <= rx_frame_data;
            idx_reg <= 4'h0;
            end_reg <= (rx_frame_len > 4'h8) ? 4'h8 : rx_frame_len;
            seq_reg <= 4'h0;
            if (!frame_ok) begin
              drop_cnt_reg <= drop_cnt_reg + 8'h01; // R16
            end else begin
              rx_frame_ready <= 1'b0;
              acc_cnt_reg <= acc_cnt_reg + 8'h01;
              if (hdr_reg) begin
                state_reg <= S_ID; // R14
              end else if (fmt_reg) begin
                case (rx_frame_data[7:4]) // R13
                  `CIF_PCI_SINGLE: begin
                    idx_reg <= 4'h1; // R15
                    end_reg <= ({1'b0, rx_frame_data[2:0]} + 4'h1 < rx_frame_len) ?
                               {1'b0, rx_frame_data[2:0]} + 4'h1 : rx_frame_len;
                    state_reg <= S_BYTE;
                  end
                  `CIF_PCI_FIRST: begin
                    idx_reg <= 4'h2;
                    state_reg <= S_LEN; // R11
                  end
                  `CIF_PCI_CONSEC: begin
                    idx_reg <= 4'h1;
                    seq_reg <= rx_frame_data[3:0]; // R12 R13
                    state_reg <= S_SEQ;
                  end
                  default: state_reg <= S_BYTE;
                endcase
              end else begin
                state_reg <= S_BYTE;
              end
            end
          end
        end
        S_ID: begin
          if (fifo_in_ready) begin
            state_reg <= S_BYTE;
          end
        end
        S_LEN: begin
          if (fifo_in_ready) begin
            state_reg <= S_LEN_EOL;
          end
        end
        S_LEN_EOL: begin
          if (fifo_in_ready) begin
            state_reg <= S_SEQ;
          end
        end
        S_SEQ: begin
          if (fifo_in_ready) begin
            state_reg <= S_BYTE;
          end
        end
        S_BYTE: begin
          if (idx_reg >= end_reg) begin
            state_reg <= S_EOL;
          end else if (fifo_in_ready) begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        S_EOL: begin
          if (fifo_in_ready) begin
            state_reg <= S_IDLE;
            rx_frame_ready <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIF_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      filter_reg <= `CIF_FILTER_RST;
      mask_reg <= `CIF_MASK_RST;
      fmt_reg <= `CIF_FMT_RST; // R9
      hdr_reg <= `CIF_HDR_RST;
      id29_reg <= `CIF_ID29_RST;
      mon_reg <= `CIF_MON_OFF;
      mon_byte_reg <= `CIF_MON_BYTE_RST;
      bus_silent <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CIF_RESP_OKAY;
        case ({awaddr_reg[7:2], 2'b00})
          `CIF_OFF_CTRL: begin
            if (wstrb_reg[1] && wdata_reg[`CIF_CTRL_DEFS_BIT]) begin
              filter_reg <= `CIF_FILTER_RST; // R8
              mask_reg <= `CIF_MASK_RST;
              fmt_reg <= `CIF_FMT_RST;
              hdr_reg <= `CIF_HDR_RST;
              id29_reg <= `CIF_ID29_RST;
              mon_reg <= `CIF_MON_OFF;
              mon_byte_reg <= `CIF_MON_BYTE_RST;
            end else begin
              fmt_reg <= wr_merged_ctrl[`CIF_CTRL_FMT_BIT];
              hdr_reg <= wr_merged_ctrl[`CIF_CTRL_HDR_BIT];
              id29_reg <= wr_merged_ctrl[`CIF_CTRL_ID29_BIT];
              mon_reg <= wr_merged_ctrl[`CIF_CTRL_MON_LSB +: 2];
            end
          end
          `CIF_OFF_FILTER: filter_reg <= wr_merged_filt[28:0]; // R1
          `CIF_OFF_MASK: mask_reg <= wr_merged_mask[28:0]; // R2
          // Short forms always replace the whole store
          `CIF_OFF_FILTER_SHRT: filter_reg <= {17'h00000, wdata_reg[11:0]}; // R4
          `CIF_OFF_MASK_SHRT: mask_reg <= {17'h00000, wdata_reg[11:0]}; // R4
          `CIF_OFF_MON_BYTE: mon_byte_reg <= wr_merged_mon[7:0];
          `CIF_OFF_STATUS: s_axi_bresp <= `CIF_RESP_OKAY;
          `CIF_OFF_RX_TOKEN: s_axi_bresp <= `CIF_RESP_OKAY;
          default: s_axi_bresp <= `CIF_RESP_SLVERR;
        endcase
      end
      // Silent while any monitor mode runs; follows the mode one cycle late
      bus_silent <= (mon_reg != `CIF_MON_OFF); // R6
    end
  end

  // Read channel; reading the token register pops one token
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CIF_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CIF_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `CIF_OFF_CTRL: s_axi_rdata <= ctrl_word;
          `CIF_OFF_FILTER: s_axi_rdata <= {3'h0, filter_reg};
          `CIF_OFF_FILTER_SHRT: s_axi_rdata <= {3'h0, filter_reg};
          `CIF_OFF_MASK: s_axi_rdata <= {3'h0, mask_reg};
          `CIF_OFF_MASK_SHRT: s_axi_rdata <= {3'h0, mask_reg};
          `CIF_OFF_MON_BYTE: s_axi_rdata <= {24'h000000, mon_byte_reg};
          `CIF_OFF_STATUS: s_axi_rdata <= status_word;
          `CIF_OFF_RX_TOKEN: s_axi_rdata <= {fifo_out_valid, fifo_out_data};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CIF_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always @* begin
    fifo_pop = s_axi_arvalid && s_axi_arready &&
               ({s_axi_araddr[7:2], 2'b00} == `CIF_OFF_RX_TOKEN);
  end
endmodule // cif_filter_display

/* verification/cif_filter_display_monitor.sv */
/* Port checker for the CAN identifier filter block.
   Assumes it is bound onto cif_filter_display, one mclk domain. */
`timescale 1ns/1ps
`include "cif_defs.vh"
module cif_filter_display_monitor (
  // Clock and reset
  input logic mclk,
  input logic rst,
  // Register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Frame port and bus state
  input logic rx_frame_valid,
  input logic rx_frame_ready,
  input logic bus_silent
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> !rx_frame_ready && !bus_silent ##1 rx_frame_ready)
    else $error("frame port wrong after reset");
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == `CIF_RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("error read carries data");
  accept_stall_a: assert property ($fell(rx_frame_ready) |-> $past(rx_frame_valid))
    else $error("frame port stalled without a frame");
  silent_cause_a: assert property ($changed(bus_silent) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("silence changed without a write");
endmodule // cif_filter_display_monitor

/* verification/cif_can_node.sv */
/* Behavioural CAN node offering received frames to the filter.
   Assumes the filter samples the frame port on the rising edge of mclk. */
`timescale 1ns/1ps
module cif_can_node (
  // Clock
  input logic mclk,
  // Frame port
  output logic rx_frame_valid,
  input logic rx_frame_ready,
  output logic [28:0] rx_frame_id,
  output logic [3:0] rx_frame_len,
  output logic [63:0] rx_frame_data,
  // Bus state
  input logic bus_silent,
  output logic [7:0] ack_count
);
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_id = 29'h0;
    rx_frame_len = 4'h0;
    rx_frame_data = 64'h0;
    ack_count = 8'h0;
  end
  task send(input logic [28:0] id, input logic [3:0] len, input logic [63:0] d, input int gap);
    begin
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      rx_frame_valid <= 1'b1;
      rx_frame_id <= id;
      rx_frame_len <= len;
      rx_frame_data <= d;
      do @(posedge mclk); while (!rx_frame_ready);
      // Released lines show the inverse so a late sample cannot pass
      rx_frame_valid <= 1'b0;
      rx_frame_id <= ~id;
      rx_frame_len <= ~len;
      rx_frame_data <= ~d;
      if (!bus_silent) ack_count <= ack_count + 8'h1;
    end
  endtask
endmodule // cif_can_node

/* verification/cif_filter_display_tb.sv */
/* Self-checking bench for cif_filter_display.
   Assumes the node model and checker are compiled before it. */
`timescale 1ns/1ps
`include "cif_defs.vh"
module cif_filter_display_tb;
  logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_frame_valid, rx_frame_ready, bus_silent;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [3:0] s_axi_wstrb, rx_frame_len;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ack_count, acks;
  logic [28:0] rx_frame_id;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [63:0] rx_frame_data;
  int n_mismatch = 0;
  int tests_run = 0;
  // Every design port has a bench signal of the same name
  cif_filter_display u_cif_filter_display (.*);
  cif_can_node can_node (.mclk(mclk), .rx_frame_valid(rx_frame_valid),
    .rx_frame_ready(rx_frame_ready), .rx_frame_id(rx_frame_id), .rx_frame_len(rx_frame_len),
    .rx_frame_data(rx_frame_data), .bus_silent(bus_silent), .ack_count(ack_count));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
        @(posedge mclk);
        if (s_axi_awvalid && s_axi_awready) begin
          s_axi_awvalid <= 1'b0;
          aw_ok = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          s_axi_wvalid <= 1'b0;
          w_ok = 1'b1;
        end
      end
      // Late ready makes the slave hold its answer
      repeat (2) @(posedge mclk);
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (!s_axi_bvalid);
      wr_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task axi_rd(input logic [7:0] a);
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge mclk);
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_rvalid);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    begin
      axi_rd(a);
      chk(rd_d, exp);
    end
  endtask
  task tok(input logic [2:0] k, input logic [27:0] p);
    int n;
    begin
      n = 0;
      rd_d = 32'h0;
      while (rd_d[31] !== 1'b1 && n < 40) begin
        axi_rd(`CIF_OFF_RX_TOKEN);
        n++;
      end
      if (k == `CIF_TOK_EOL) chk({28'h0, rd_d[31:28]}, {28'h0, 1'b1, k});
      else chk(rd_d, {1'b1, k, p});
    end
  endtask
  task no_tok;
    begin
      axi_rd(`CIF_OFF_RX_TOKEN);
      chk({31'h0, rd_d[31]}, 32'h0);
    end
  endtask
  // Expected tokens of one accepted frame
  task exp_frame(input logic [28:0] id, input logic [63:0] d, input int len, input logic hdr);
    int lo, hi, i;
    begin
      lo = 1;
      hi = len;
      if (hdr) begin
        tok(`CIF_TOK_ID, id[27:0]);
        lo = 0;
      end else if (d[7:4] == `CIF_PCI_SINGLE) begin
        hi = (d[2:0] + 1 < len) ? d[2:0] + 1 : len;
      end else if (d[7:4] == `CIF_PCI_FIRST) begin
        tok(`CIF_TOK_LEN, {16'h0, d[3:0], d[15:8]});
        tok(`CIF_TOK_EOL, 28'h0);
        tok(`CIF_TOK_SEQ, 28'h0);
        lo = 2;
      end else if (d[7:4] == `CIF_PCI_CONSEC) begin
        tok(`CIF_TOK_SEQ, {24'h0, d[3:0]});
      end
      for (i = lo; i < hi; i++) tok(`CIF_TOK_BYTE, {20'h0, d[8*i +: 8]});
      tok(`CIF_TOK_EOL, 28'h0);
    end
  endtask
  task t_regs;
    begin
      rdchk(`CIF_OFF_CTRL, 32'h1);
      rdchk(`CIF_OFF_FILTER, 32'h0);
      rdchk(`CIF_OFF_MASK, 32'h0);
      axi_rd(8'h20);
      chk({rd_r, rd_d[29:0]}, {`CIF_RESP_SLVERR, 30'h0});
      axi_wr(8'h24, 32'h1);
      chk({30'h0, wr_r}, {30'h0, `CIF_RESP_SLVERR});
      $display("test registers done");
    end
  endtask
  task t_filter;
    begin
      axi_wr(`CIF_OFF_CTRL, 32'h5);
      axi_wr(`CIF_OFF_FILTER, 32'h18daf100);
      axi_wr(`CIF_OFF_MASK, 32'h1fffff00);
      rdchk(`CIF_OFF_FILTER, 32'h18daf100);
      can_node.send(29'h18daf13a, 4'h2, 64'h9901, 0);
      exp_frame(29'h0, 64'h9901, 2, 1'b0);
      can_node.send(29'h18daf23a, 4'h2, 64'h9901, 3);
      repeat (10) @(posedge mclk);
      no_tok;
      axi_wr(`CIF_OFF_CTRL, 32'h1);
      axi_wr(`CIF_OFF_FILTER_SHRT, 32'hfffff600);
      axi_wr(`CIF_OFF_MASK_SHRT, 32'h00000f00);
      rdchk(`CIF_OFF_FILTER, 32'h600);
      rdchk(`CIF_OFF_MASK, 32'hf00);
      can_node.send(29'h1ffffea5, 4'h2, 64'h7701, 0);
      exp_frame(29'h0, 64'h7701, 2, 1'b0);
      can_node.send(29'h2a5, 4'h2, 64'h7701, 0);
      repeat (10) @(posedge mclk);
      no_tok;
      axi_rd(`CIF_OFF_STATUS);
      chk({16'h0, rd_d[23:8]}, 32'h0202);
      $display("test filter done");
    end
  endtask
  task t_multi;
    begin
      axi_wr(`CIF_OFF_MASK_SHRT, 32'h0);
      can_node.send(29'h7e8, 4'h8, 64'h3444310102491410, 2);
      repeat (20) @(posedge mclk);
      axi_rd(`CIF_OFF_STATUS);
      chk({27'h0, rd_d[4:0]}, 32'h11);
      exp_frame(29'h0, 64'h3444310102491410, 8, 1'b0);
      no_tok;
      can_node.send(29'h7e8, 4'h8, 64'h3535523030504721, 0);
      exp_frame(29'h0, 64'h3535523030504721, 8, 1'b0);
      can_node.send(29'h7e8, 4'h2, 64'haa2f, 0);
      exp_frame(29'h0, 64'haa2f, 2, 1'b0);
      can_node.send(29'h7e8, 4'h2, 64'hbb20, 0);
      exp_frame(29'h0, 64'hbb20, 2, 1'b0);
      can_node.send(29'h7e8, 4'h3, 64'h054102, 0);
      exp_frame(29'h0, 64'h054102, 3, 1'b0);
      axi_wr(`CIF_OFF_CTRL, 32'h3);
      can_node.send(29'h1ffff7e8, 4'h8, 64'h3444310102491410, 0);
      exp_frame(29'h7e8, 64'h3444310102491410, 8, 1'b1);
      $display("test multiframe done");
    end
  endtask
  task t_monitor;
    int m;
    begin
      axi_wr(`CIF_OFF_FILTER_SHRT, 32'h600);
      axi_wr(`CIF_OFF_MASK_SHRT, 32'h700);
      axi_wr(`CIF_OFF_MON_BYTE, 32'h10);
      for (m = 1; m < 4; m++) begin
        axi_wr(`CIF_OFF_CTRL, {26'h0, m[1:0], 4'h1});
        repeat (2) @(posedge mclk);
        chk({31'h0, bus_silent}, 32'h1);
      end
      acks = ack_count;
      can_node.send(29'h610, 4'h2, 64'h5501, 0);
      exp_frame(29'h0, 64'h5501, 2, 1'b0);
      can_node.send(29'h710, 4'h2, 64'h5501, 0);
      can_node.send(29'h611, 4'h2, 64'h5501, 0);
      repeat (10) @(posedge mclk);
      no_tok;
      chk({24'h0, ack_count}, {24'h0, acks});
      axi_wr(`CIF_OFF_CTRL, 32'h21);
      axi_wr(`CIF_OFF_MON_BYTE, 32'h0e);
      can_node.send(29'h6aa, 4'h2, 64'h6601, 0);
      exp_frame(29'h0, 64'h6601, 2, 1'b0);
      axi_wr(`CIF_OFF_CTRL, 32'h100);
      rdchk(`CIF_OFF_CTRL, 32'h1);
      rdchk(`CIF_OFF_FILTER, 32'h0);
      rdchk(`CIF_OFF_MASK, 32'h0);
      chk({31'h0, bus_silent}, 32'h0);
      can_node.send(29'h123, 4'h2, 64'h4401, 0);
      exp_frame(29'h0, 64'h4401, 2, 1'b0);
      $display("test monitor done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_regs;
    t_filter;
    t_multi;
    t_monitor;
    report_and_stop;
  end
endmodule // cif_filter_display_tb
bind cif_filter_display cif_filter_display_monitor u_mon (.*);
